// file: design/interrupt_priority_fields_pkg.sv
package interrupt_priority_fields_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ENCODER_PWM_MATCH_PRIORITY_ADDR = 4'h0;
  localparam logic [3:0] ADC_PAIRS_UPPER_PRIORITY_ADDR   = 4'h1;

  // field positions (low bit of each 3-bit field)
  localparam int ENCODER_TWO_PRIORITY_POS         = 12;
  localparam int PWM_SECONDARY_MATCH_PRIORITY_POS = 4;
  localparam int ADC_PAIR_TEN_PRIORITY_POS        = 12;
  localparam int ADC_PAIR_NINE_PRIORITY_POS       = 8;
  localparam int ADC_PAIR_EIGHT_PRIORITY_POS      = 4;

  // implemented-bit masks
  localparam logic [15:0] ENCODER_PWM_MATCH_MASK = 16'h7070;
  localparam logic [15:0] ADC_PAIRS_UPPER_MASK   = 16'h7770;

  // field reset value and disable code
  localparam logic [2:0] PRIORITY_RESET    = 3'h4;
  localparam logic [2:0] PRIORITY_DISABLED = 3'h0;

  typedef logic [2:0] priority_t;

endpackage

// file: design/interrupt_priority_fields.sv
// Contract
// [RULE1] register seventeen: encoder-two priority bits 14-12, pwm match bits 6-4, reset 100
// [RULE2] register eighteen: adc pair ten 14-12, nine 10-8, eight 6-4, reset 100
// [RULE3] field value is level; 111 highest, 001 lowest, 000 disables source
// [RULE4] unimplemented bits read zero and ignore writes
// [RULE5] fields drive arbitration continuously; disabled source never signalled pending
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module interrupt_priority_fields
  import interrupt_priority_fields_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output      logic [15:0] regRdData,
  // raw request flags from the five sources, order: enc2, pwm, adc10, adc9, adc8
  input  wire logic [4:0]  sourceRequest,
  // priorities to the arbitration core
  output      priority_t   encoderTwoPriority,
  output      priority_t   pwmSecondaryMatchPriority,
  output      priority_t   adcPairTenPriority,
  output      priority_t   adcPairNinePriority,
  output      priority_t   adcPairEightPriority,
  // pending requests that may be arbitrated
  output      logic [4:0]  sourcePending
);

  logic [15:0] encoderPwmMatchPriority;
  logic [15:0] adcPairsUpperPriority;
  logic [15:0] next_regRdData;
  priority_t   levelEncoderTwo;
  priority_t   levelPwmMatch;
  priority_t   levelPairTen;
  priority_t   levelPairNine;
  priority_t   levelPairEight;

  // one 3-bit priority field out of a register image
  function automatic priority_t field_at(input logic [15:0] image, input int pos);
    return image[pos +: 3];
  endfunction

  // a level of 000 takes the source out of arbitration
  function automatic logic level_enabled(input priority_t level);
    return level != PRIORITY_DISABLED;
  endfunction

  // stored levels, shared by the output copy and the request gating
  assign levelEncoderTwo = field_at(encoderPwmMatchPriority, ENCODER_TWO_PRIORITY_POS); // RULE1
  assign levelPwmMatch   = field_at(encoderPwmMatchPriority, PWM_SECONDARY_MATCH_PRIORITY_POS); // RULE1
  assign levelPairTen    = field_at(adcPairsUpperPriority, ADC_PAIR_TEN_PRIORITY_POS); // RULE2
  assign levelPairNine   = field_at(adcPairsUpperPriority, ADC_PAIR_NINE_PRIORITY_POS); // RULE2
  assign levelPairEight  = field_at(adcPairsUpperPriority, ADC_PAIR_EIGHT_PRIORITY_POS); // RULE2

  // write register seventeen, only implemented bits
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      encoderPwmMatchPriority <= {1'b0, PRIORITY_RESET, 5'h00, PRIORITY_RESET, 4'h0}; // RULE1
    end else if (regWrite && regAddr == ENCODER_PWM_MATCH_PRIORITY_ADDR) begin
      encoderPwmMatchPriority <= regWrData & ENCODER_PWM_MATCH_MASK; // RULE1 RULE4
    end
  end

  // write register eighteen, only implemented bits
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adcPairsUpperPriority <= {1'b0, PRIORITY_RESET, 1'b0, PRIORITY_RESET, 1'b0, PRIORITY_RESET, 4'h0}; // RULE2
    end else if (regWrite && regAddr == ADC_PAIRS_UPPER_PRIORITY_ADDR) begin
      adcPairsUpperPriority <= regWrData & ADC_PAIRS_UPPER_MASK; // RULE2 RULE4
    end
  end

  // read decode, unmapped reads zero
  always_comb begin
    next_regRdData = 16'h0000;
    if (regRead) begin
      case (regAddr)
        ENCODER_PWM_MATCH_PRIORITY_ADDR: next_regRdData = encoderPwmMatchPriority & ENCODER_PWM_MATCH_MASK; // RULE4
        ADC_PAIRS_UPPER_PRIORITY_ADDR:   next_regRdData = adcPairsUpperPriority & ADC_PAIRS_UPPER_MASK; // RULE4
        default:                         next_regRdData = 16'h0000;
      endcase
    end
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // priority outputs follow the stored fields
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      encoderTwoPriority        <= PRIORITY_RESET;
      pwmSecondaryMatchPriority <= PRIORITY_RESET;
      adcPairTenPriority        <= PRIORITY_RESET;
      adcPairNinePriority       <= PRIORITY_RESET;
      adcPairEightPriority      <= PRIORITY_RESET;
    end else begin
      encoderTwoPriority        <= levelEncoderTwo; // RULE5 RULE3
      pwmSecondaryMatchPriority <= levelPwmMatch; // RULE5 RULE3
      adcPairTenPriority        <= levelPairTen; // RULE5 RULE3
      adcPairNinePriority       <= levelPairNine; // RULE5 RULE3
      adcPairEightPriority      <= levelPairEight; // RULE5 RULE3
    end
  end

  // request gated by a non-zero level; sourceRequest comes from same-clock logic
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sourcePending <= 5'h00;
    end else begin
      sourcePending[4] <= sourceRequest[4] && level_enabled(levelEncoderTwo); // RULE3 RULE5
      sourcePending[3] <= sourceRequest[3] && level_enabled(levelPwmMatch); // RULE3 RULE5
      sourcePending[2] <= sourceRequest[2] && level_enabled(levelPairTen); // RULE3 RULE5
      sourcePending[1] <= sourceRequest[1] && level_enabled(levelPairNine); // RULE3 RULE5
      sourcePending[0] <= sourceRequest[0] && level_enabled(levelPairEight); // RULE3 RULE5
    end
  end

  // checks
  property p_reserved_zero;
    @(posedge ref_clk) disable iff (sys_rst)
      ((regRdData & ~(ENCODER_PWM_MATCH_MASK | ADC_PAIRS_UPPER_MASK)) == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // RULE4

  property p_read_seventeen;
    @(posedge ref_clk) disable iff (sys_rst)
      regRead && regAddr == ENCODER_PWM_MATCH_PRIORITY_ADDR |=>
        regRdData == {1'b0, encoderTwoPriority, 5'h00, pwmSecondaryMatchPriority, 4'h0};
  endproperty
  a_read_seventeen: assert property (p_read_seventeen) else $error("register seventeen read mismatch"); // RULE1

  property p_read_eighteen;
    @(posedge ref_clk) disable iff (sys_rst)
      regRead && regAddr == ADC_PAIRS_UPPER_PRIORITY_ADDR |=>
        regRdData == {1'b0, adcPairTenPriority, 1'b0, adcPairNinePriority, 1'b0, adcPairEightPriority, 4'h0};
  endproperty
  a_read_eighteen: assert property (p_read_eighteen) else $error("register eighteen read mismatch"); // RULE2

  property p_write_encoder;
    @(posedge ref_clk) disable iff (sys_rst)
      regWrite && regAddr == ENCODER_PWM_MATCH_PRIORITY_ADDR |=>
        ##1 encoderTwoPriority == $past(regWrData[14:12], 2);
  endproperty
  a_write_encoder: assert property (p_write_encoder) else $error("encoder priority not written"); // RULE1

  property p_write_pair_nine;
    @(posedge ref_clk) disable iff (sys_rst)
      regWrite && regAddr == ADC_PAIRS_UPPER_PRIORITY_ADDR |=>
        ##1 adcPairNinePriority == $past(regWrData[10:8], 2);
  endproperty
  a_write_pair_nine: assert property (p_write_pair_nine) else $error("pair nine priority not written"); // RULE2

  property p_disabled_never_pending;
    @(posedge ref_clk) disable iff (sys_rst)
      (adcPairEightPriority == PRIORITY_DISABLED && $stable(adcPairEightPriority)) |-> !sourcePending[0];
  endproperty
  a_disabled_never_pending: assert property (p_disabled_never_pending) else $error("disabled source pending"); // RULE5

  property p_enabled_pending;
    @(posedge ref_clk) disable iff (sys_rst)
      sourceRequest[4] && encoderPwmMatchPriority[14:12] != PRIORITY_DISABLED |=> sourcePending[4];
  endproperty
  a_enabled_pending: assert property (p_enabled_pending) else $error("enabled request lost"); // RULE3

  property p_idle_read_zero;
    @(posedge ref_clk) disable iff (sys_rst)
      !regRead |=> regRdData == 16'h0000;
  endproperty
  a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data outside read slot"); // RULE4

  property p_write_pwm;
    @(posedge ref_clk) disable iff (sys_rst)
      regWrite && regAddr == ENCODER_PWM_MATCH_PRIORITY_ADDR |=>
        ##1 pwmSecondaryMatchPriority == $past(regWrData[6:4], 2);
  endproperty
  a_write_pwm: assert property (p_write_pwm) else $error("pwm match priority not written"); // RULE1

  property p_write_pair_ten;
    @(posedge ref_clk) disable iff (sys_rst)
      regWrite && regAddr == ADC_PAIRS_UPPER_PRIORITY_ADDR |=>
        ##1 adcPairTenPriority == $past(regWrData[14:12], 2);
  endproperty
  a_write_pair_ten: assert property (p_write_pair_ten) else $error("pair ten priority not written"); // RULE2

  property p_write_pair_eight;
    @(posedge ref_clk) disable iff (sys_rst)
      regWrite && regAddr == ADC_PAIRS_UPPER_PRIORITY_ADDR |=>
        ##1 adcPairEightPriority == $past(regWrData[6:4], 2);
  endproperty
  a_write_pair_eight: assert property (p_write_pair_eight) else $error("pair eight priority not written"); // RULE2

  // unimplemented bits must never be stored, whatever the write data holds
  property p_reserved_never_stored;
    @(posedge ref_clk) disable iff (sys_rst)
      ((encoderPwmMatchPriority & ~ENCODER_PWM_MATCH_MASK) == 16'h0000) &&
        ((adcPairsUpperPriority & ~ADC_PAIRS_UPPER_MASK) == 16'h0000);
  endproperty
  a_reserved_never_stored: assert property (p_reserved_never_stored) else $error("reserved bits stored"); // RULE4

  // levels seen by the arbitration core only move after a write
  property p_levels_stand;
    @(posedge ref_clk) disable iff (sys_rst)
      !regWrite |=>
        ##1 ($stable(encoderTwoPriority) && $stable(adcPairEightPriority));
  endproperty
  a_levels_stand: assert property (p_levels_stand) else $error("priority level moved without a write"); // RULE5

  // writes to unmapped indices leave both registers alone
  property p_unmapped_write_ignored;
    @(posedge ref_clk) disable iff (sys_rst)
      regWrite && regAddr != ENCODER_PWM_MATCH_PRIORITY_ADDR && regAddr != ADC_PAIRS_UPPER_PRIORITY_ADDR |=>
        $stable(encoderPwmMatchPriority) && $stable(adcPairsUpperPriority);
  endproperty
  a_unmapped_write_ignored: assert property (p_unmapped_write_ignored) else $error("unmapped write landed"); // RULE4

  c_write_seventeen: cover property (@(posedge ref_clk) regWrite && regAddr == ENCODER_PWM_MATCH_PRIORITY_ADDR);
  c_read_eighteen: cover property (@(posedge ref_clk) regRead && regAddr == ADC_PAIRS_UPPER_PRIORITY_ADDR);
  c_disabled_source: cover property (@(posedge ref_clk) adcPairEightPriority == PRIORITY_DISABLED);
  c_write_then_read: cover property (@(posedge ref_clk) regWrite ##1 regRead);
  c_pending_raised: cover property (@(posedge ref_clk) sourcePending[4]);

endmodule

// file: testbench/interrupt_priority_fields_tb_top.sv
`timescale 1ns/100ps
module interrupt_priority_fields_tb_top
  import interrupt_priority_fields_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regRdData;
  logic [4:0]  sourceRequest = 5'h0;
  priority_t   prio [5];
  logic [4:0]  sourcePending;
  logic [31:0] seed = 32'hA781B656;
  int          num_errors = 0;
  int          check_count = 0;
  int          mreg [2];

  // clock and device under test
  always #2.5 ref_clk = ~ref_clk;
  interrupt_priority_fields u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .sourceRequest(sourceRequest), .encoderTwoPriority(prio[4]), .pwmSecondaryMatchPriority(prio[3]),
    .adcPairTenPriority(prio[2]), .adcPairNinePriority(prio[1]), .adcPairEightPriority(prio[0]),
    .sourcePending(sourcePending));

  // random source: shift register step
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one write cycle; model keeps implemented bits of mapped registers only
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    if (a == 4'h0) mreg[0] = d & ENCODER_PWM_MATCH_MASK;
    if (a == 4'h1) mreg[1] = d & ADC_PAIRS_UPPER_MASK;
  endtask

  // one read cycle; data checked in the following cycle, zero in the one after
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    chk(regRdData, (a < 4'h2) ? 16'(mreg[a]) : 16'h0);
    @(negedge ref_clk);
    chk(regRdData, 16'h0000);
  endtask

  // write then read at the very next edge; the read must see the new value
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    if (a == 4'h0) mreg[0] = d & ENCODER_PWM_MATCH_MASK;
    if (a == 4'h1) mreg[1] = d & ADC_PAIRS_UPPER_MASK;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    chk(regRdData, (a < 4'h2) ? 16'(mreg[a]) : 16'h0);
  endtask

  // priority outputs and request gating against the model
  task automatic check_out();
    int f [5];
    logic [4:0] req;
    f = '{(mreg[1] >> 4) & 7, (mreg[1] >> 8) & 7, (mreg[1] >> 12) & 7, (mreg[0] >> 4) & 7, (mreg[0] >> 12) & 7};
    seed = lfsr(seed);
    req = seed[4:0];
    @(posedge ref_clk);
    sourceRequest <= req;
    @(posedge ref_clk);
    @(negedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      chk(16'(prio[i]), 16'(f[i]));
      chk(16'(sourcePending[i]), 16'(req[i] && f[i] != 0));
    end
  endtask

  // full pass: all addresses read, outputs compared
  task automatic sweep();
    for (int a = 0; a < 16; a++) rd(4'(a));
    repeat (3) check_out();
  endtask

  initial begin
    for (int r = 0; r < 2; r++) begin
      sys_rst <= 1'b1;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      mreg = '{16'h4040, 16'h4440};
      sweep();
      // every field code, unimplemented bits set at random, unmapped writes too
      for (int i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        wr_rd(4'(seed[20]), seed[15:0] ^ seed[31:16]);
        wr(4'h0, (seed[15:0] & 16'h8F8F) | 16'(i * 16'h1111));
        wr(4'h1, (seed[31:16] & 16'h888F) | 16'(i * 16'h1111));
        wr(4'(2 + seed[3:0] % 14), seed[31:16]);
        sweep();
      end
    end
    print_verdict();
  end

  // hang guard
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule
